// file: src/pivtc_top.sv
// Per-port ingress control and default tag registers of a four-port
// switch, with the per-frame ingress decision they steer.
// Assumes an AXI4-Lite master on aclk and one lookup request per
// cycle at most from the ingress parser, port 1..4 coded 0..3.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "pivtc_defs.svh"

module pivtc_top (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write address, data and response
  input  wire logic [`PIVTC_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]               awprot,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // AXI4-Lite read
  input  wire logic [`PIVTC_ADDR_W-1:0] araddr,
  input  wire logic [2:0]               arprot,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // Ingress lookup request
  input  wire logic                     pkt_valid,
  input  wire logic [1:0]               pkt_port,
  input  wire logic [11:0]              pkt_vid,
  input  wire logic [2:0]               pkt_prio,
  input  wire logic [4:0]               pkt_vlan_member,
  // Ingress lookup result
  output logic                          res_valid,
  output logic                          res_drop,
  output logic [2:0]                    res_prio,
  output logic                          res_learn,
  // Per-port state
  input  wire logic [3:0]               auto_negotiation_result_rx,
  input  wire logic [3:0]               auto_negotiation_result_tx,
  output logic [3:0]                    flow_ctrl_rx_en,
  output logic [3:0]                    flow_ctrl_tx_en,
  output logic [3:0]                    rx_enable,
  output logic [3:0]                    learn_enable
);

  logic [7:0]                   ctrl       [4];
  logic [7:0]                   tag_hi     [4];
  logic [7:0]                   tag_lo     [4];
  pivtc_pkg::pivtc_wr_state_t   wr_state;
  pivtc_pkg::pivtc_wr_state_t   next_wr_state;
  logic [`PIVTC_ADDR_W-1:0]     aw_addr_q;
  logic [7:0]                   w_data_q;
  logic                         w_strb_q;
  logic                         aw_fire;
  logic                         w_fire;
  logic                         do_write;
  logic [`PIVTC_ADDR_W-1:0]     wr_addr;
  logic [7:0]                   wr_data;
  logic                         wr_strb;
  pivtc_pkg::pivtc_dec_t        wr_dec;
  pivtc_pkg::pivtc_dec_t        rd_dec;

  // Decode a byte address into port slot and register kind
  // address map
  function automatic pivtc_pkg::pivtc_dec_t dec_addr(
    input logic [`PIVTC_ADDR_W-1:0] addr
  );
    pivtc_pkg::pivtc_dec_t d;
    logic [`PIVTC_IDX_W-1:0] idx;
    d = '{hit: 1'b1, rsvd: 1'b0, slot: `PIVTC_SLOT_P1,
          kind: pivtc_pkg::PIVTC_K_NONE};
    idx = addr[`PIVTC_ADDR_W-1:`PIVTC_IDX_LSB];
    case (idx)
      `PIVTC_P1_CTRL2  : d.kind = pivtc_pkg::PIVTC_K_CTRL2;
      `PIVTC_P1_TAG_HI : d.kind = pivtc_pkg::PIVTC_K_TAG_HI;
      `PIVTC_P1_TAG_LO : d.kind = pivtc_pkg::PIVTC_K_TAG_LO;
      `PIVTC_P2_CTRL2  : d = '{1'b1, 1'b0, `PIVTC_SLOT_P2,
                               pivtc_pkg::PIVTC_K_CTRL2};
      `PIVTC_P2_TAG_HI : d = '{1'b1, 1'b0, `PIVTC_SLOT_P2,
                               pivtc_pkg::PIVTC_K_TAG_HI};
      `PIVTC_P2_TAG_LO : d = '{1'b1, 1'b0, `PIVTC_SLOT_P2,
                               pivtc_pkg::PIVTC_K_TAG_LO};
      `PIVTC_P3_CTRL2  : d = '{1'b1, 1'b0, `PIVTC_SLOT_P3,
                               pivtc_pkg::PIVTC_K_CTRL2};
      `PIVTC_P3_TAG_HI : d = '{1'b1, 1'b0, `PIVTC_SLOT_P3,
                               pivtc_pkg::PIVTC_K_TAG_HI};
      `PIVTC_P3_TAG_LO : d = '{1'b1, 1'b0, `PIVTC_SLOT_P3,
                               pivtc_pkg::PIVTC_K_TAG_LO};
      `PIVTC_P4_CTRL2  : d = '{1'b1, 1'b0, `PIVTC_SLOT_P4,
                               pivtc_pkg::PIVTC_K_CTRL2};
      `PIVTC_P4_TAG_HI : d = '{1'b1, 1'b0, `PIVTC_SLOT_P4,
                               pivtc_pkg::PIVTC_K_TAG_HI};
      `PIVTC_P4_TAG_LO : d = '{1'b1, 1'b0, `PIVTC_SLOT_P4,
                               pivtc_pkg::PIVTC_K_TAG_LO};
      // Reserved slots answer OKAY, read zero, ignore writes
      `PIVTC_RSV_CTRL2,
      `PIVTC_RSV_TAG_HI,
      `PIVTC_RSV_TAG_LO: d.rsvd = 1'b1;
      default          : d.hit = 1'b0;
    endcase
    return d;
  endfunction : dec_addr

  // Membership field bit that stands for a port; bit 3 is unused
  function automatic logic [2:0] memb_bit(input logic [1:0] slot);
    return (slot == `PIVTC_SLOT_P4) ? `PIVTC_MEMB_P4 : {1'b0, slot};
  endfunction : memb_bit

  // Write channel: address and data taken in either order
  assign aw_fire  = awvalid && awready;
  assign w_fire   = wvalid && wready;
  assign wr_addr  = aw_fire ? awaddr : aw_addr_q;
  assign wr_data  = w_fire ? wdata[7:0] : w_data_q;
  assign wr_strb  = w_fire ? wstrb[0] : w_strb_q;
  assign wr_dec   = dec_addr(wr_addr);
  assign do_write = (next_wr_state == pivtc_pkg::PIVTC_WR_RESP)
                    && (wr_state != pivtc_pkg::PIVTC_WR_RESP);

  always_comb
  begin
    next_wr_state = wr_state;
    case (wr_state)
      pivtc_pkg::PIVTC_WR_IDLE:
        if (aw_fire && w_fire)
          next_wr_state = pivtc_pkg::PIVTC_WR_RESP;
        else if (aw_fire)
          next_wr_state = pivtc_pkg::PIVTC_WR_ADDR;
        else if (w_fire)
          next_wr_state = pivtc_pkg::PIVTC_WR_DATA;
      pivtc_pkg::PIVTC_WR_ADDR:
        if (w_fire)
          next_wr_state = pivtc_pkg::PIVTC_WR_RESP;
      pivtc_pkg::PIVTC_WR_DATA:
        if (aw_fire)
          next_wr_state = pivtc_pkg::PIVTC_WR_RESP;
      pivtc_pkg::PIVTC_WR_RESP:
        if (bready)
          next_wr_state = pivtc_pkg::PIVTC_WR_IDLE;
      default:
        next_wr_state = pivtc_pkg::PIVTC_WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state  <= pivtc_pkg::PIVTC_WR_IDLE;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `PIVTC_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 1'b0;
    end
    else
    begin
      wr_state <= next_wr_state;
      awready  <= (next_wr_state == pivtc_pkg::PIVTC_WR_IDLE)
                  || (next_wr_state == pivtc_pkg::PIVTC_WR_DATA);
      wready   <= (next_wr_state == pivtc_pkg::PIVTC_WR_IDLE)
                  || (next_wr_state == pivtc_pkg::PIVTC_WR_ADDR);
      bvalid   <= (next_wr_state == pivtc_pkg::PIVTC_WR_RESP);
      if (do_write)
        bresp <= wr_dec.hit ? `PIVTC_RESP_OKAY : `PIVTC_RESP_DECERR;
      if (aw_fire)
        aw_addr_q <= awaddr;
      if (w_fire)
      begin
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end
    end
  end

  // Register bank; only byte lane 0 carries the 8-bit registers
  // reset values
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ctrl[i]   <= `PIVTC_RST_CTRL2;
        tag_hi[i] <= `PIVTC_RST_TAG_HI;
        tag_lo[i] <= `PIVTC_RST_TAG_LO;
      end
    end
    else if (do_write && wr_strb && wr_dec.hit && !wr_dec.rsvd)
    begin
      case (wr_dec.kind)
        pivtc_pkg::PIVTC_K_CTRL2 : ctrl[wr_dec.slot]   <= wr_data;
        pivtc_pkg::PIVTC_K_TAG_HI: tag_hi[wr_dec.slot] <= wr_data;
        pivtc_pkg::PIVTC_K_TAG_LO: tag_lo[wr_dec.slot] <= wr_data;
        default                  : ;
      endcase
    end
  end

  // Read channel: one read in flight, data registered on acceptance
  assign rd_dec = dec_addr(araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `PIVTC_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= rd_dec.hit ? `PIVTC_RESP_OKAY : `PIVTC_RESP_DECERR;
      case (rd_dec.kind)
        pivtc_pkg::PIVTC_K_CTRL2 : rdata <= {24'h0, ctrl[rd_dec.slot]};
        pivtc_pkg::PIVTC_K_TAG_HI: rdata <= {24'h0, tag_hi[rd_dec.slot]};
        pivtc_pkg::PIVTC_K_TAG_LO: rdata <= {24'h0, tag_lo[rd_dec.slot]};
        default                  : rdata <= '0;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // Ingress decision, one cycle after the request
  logic [7:0] p_ctrl;
  logic [7:0] p_thi;
  logic [7:0] p_tlo;
  logic [2:0] def_prio;
  logic       memb_miss;
  logic       vid_miss;
  assign p_ctrl    = ctrl[pkt_port];
  assign p_thi     = tag_hi[pkt_port];
  assign p_tlo     = tag_lo[pkt_port];
  assign def_prio  = p_thi[`PIVTC_PRIO_HI:`PIVTC_PRIO_LO];
  assign memb_miss = !pkt_vlan_member[memb_bit(pkt_port)];
  assign vid_miss  = pkt_vid != {p_thi[`PIVTC_VIDH_HI:0], p_tlo};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_valid <= 1'b0;
      res_drop  <= 1'b0;
      res_prio  <= '0;
      res_learn <= 1'b0;
    end
    else
    begin
      res_valid <= pkt_valid;
      res_drop  <= !p_ctrl[`PIVTC_B_RXEN]
                   || (p_ctrl[`PIVTC_B_FILT] && memb_miss)
                   || (p_ctrl[`PIVTC_B_DISC] && vid_miss);
      res_prio  <= (p_ctrl[`PIVTC_B_CEIL] && pkt_prio > def_prio)
                   ? def_prio : pkt_prio;
      res_learn <= !p_ctrl[`PIVTC_B_LDIS];
    end
  end

  // Per-port levels toward the MACs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flow_ctrl_rx_en <= '0;
      flow_ctrl_tx_en <= '0;
      rx_enable       <= '0;
      learn_enable    <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        flow_ctrl_rx_en[i] <= ctrl[i][`PIVTC_B_FFC]
                              || auto_negotiation_result_rx[i];
        flow_ctrl_tx_en[i] <= ctrl[i][`PIVTC_B_FFC]
                              || auto_negotiation_result_tx[i];
        rx_enable[i]       <= ctrl[i][`PIVTC_B_RXEN];
        learn_enable[i]    <= !ctrl[i][`PIVTC_B_LDIS];
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_prio_ceiling: assert property (res_valid |-> res_prio ==
    (($past(p_ctrl[`PIVTC_B_CEIL]) && $past(pkt_prio) > $past(def_prio))
     ? $past(def_prio) : $past(pkt_prio)))
    else $error("priority ceiling wrong");
  a_vlan_filter: assert property ((pkt_valid && memb_miss
    && p_ctrl[`PIVTC_B_FILT]) |=> res_valid && res_drop)
    else $error("filtered frame not dropped");
  a_port_default_vlan_id_discard: assert property ((pkt_valid && vid_miss
    && p_ctrl[`PIVTC_B_DISC]) |=> res_drop)
    else $error("non-default VID frame not dropped");
  a_forced_flow: assert property (ctrl[2][`PIVTC_B_FFC]
    ##1 ctrl[2][`PIVTC_B_FFC] |-> flow_ctrl_rx_en[2] && flow_ctrl_tx_en[2])
    else $error("forced flow control ignored");
  a_rx_disable: assert property ((pkt_valid
    && !p_ctrl[`PIVTC_B_RXEN]) |=> res_drop)
    else $error("frame accepted while receive disabled");
  a_learn_gate: assert property ((pkt_valid
    && p_ctrl[`PIVTC_B_LDIS]) |=> !res_learn)
    else $error("learning while disabled");
  a_tag_high_rst: assert property ($rose(aresetn) |->
    tag_hi[0] == `PIVTC_RST_TAG_HI && tag_hi[3] == `PIVTC_RST_TAG_HI)
    else $error("tag high reset value wrong");
  a_tag_low_rst: assert property ($rose(aresetn) |->
    tag_lo[1] == `PIVTC_RST_TAG_LO && ctrl[1] == `PIVTC_RST_CTRL2)
    else $error("tag low or control reset value wrong");
  a_rsvd_read: assert property ((arvalid && arready && rd_dec.rsvd)
    |=> rvalid && rdata == '0 && rresp == `PIVTC_RESP_OKAY)
    else $error("reserved slot read not zero");
  a_tag_lo_read: assert property ((arvalid && arready
    && araddr[`PIVTC_ADDR_W-1:`PIVTC_IDX_LSB] == `PIVTC_P4_TAG_LO)
    |=> rdata[7:0] == $past(tag_lo[3]))
    else $error("port 4 tag low read wrong");
  a_ctrl_write: assert property ((do_write && wr_strb
    && wr_addr[`PIVTC_ADDR_W-1:`PIVTC_IDX_LSB] == `PIVTC_P3_CTRL2)
    |=> ctrl[2] == $past(wr_data) && bvalid)
    else $error("port 3 control write lost");
  a_drop_either: assert property ((pkt_valid
    && p_ctrl[`PIVTC_B_FILT] && p_ctrl[`PIVTC_B_DISC]
    && p_ctrl[`PIVTC_B_RXEN])
    |=> res_drop == ($past(memb_miss) || $past(vid_miss)))
    else $error("drop with both checks on wrong");

  c_ceiling_hit: cover property (res_valid && $past(pkt_prio)
    > res_prio);
  c_both_drop: cover property (pkt_valid && memb_miss && vid_miss
    && p_ctrl[`PIVTC_B_FILT] && p_ctrl[`PIVTC_B_DISC] ##1 res_drop);
  c_split_write: cover property (wr_state == pivtc_pkg::PIVTC_WR_DATA
    ##[1:8] bvalid);

endmodule : pivtc_top

// file: src/pivtc_defs.svh
// Constants of the per-port ingress VLAN and tag control bank.
// Assumes a byte-wide register at word index = printed offset.
`ifndef PIVTC_DEFS_SVH
`define PIVTC_DEFS_SVH

`define PIVTC_ADDR_W      9
`define PIVTC_IDX_W       7
`define PIVTC_IDX_LSB     2

// Register indices (byte address is four times the index)
`define PIVTC_P1_CTRL2    7'h12
`define PIVTC_P1_TAG_HI   7'h13
`define PIVTC_P1_TAG_LO   7'h14
`define PIVTC_P2_CTRL2    7'h22
`define PIVTC_P2_TAG_HI   7'h23
`define PIVTC_P2_TAG_LO   7'h24
`define PIVTC_P3_CTRL2    7'h32
`define PIVTC_P3_TAG_HI   7'h33
`define PIVTC_P3_TAG_LO   7'h34
`define PIVTC_RSV_CTRL2   7'h42
`define PIVTC_RSV_TAG_HI  7'h43
`define PIVTC_RSV_TAG_LO  7'h44
`define PIVTC_P4_CTRL2    7'h52
`define PIVTC_P4_TAG_HI   7'h53
`define PIVTC_P4_TAG_LO   7'h54

// Port slots
`define PIVTC_SLOT_P1     2'h0
`define PIVTC_SLOT_P2     2'h1
`define PIVTC_SLOT_P3     2'h2
`define PIVTC_SLOT_P4     2'h3

// Control register bits
`define PIVTC_B_CEIL      7
`define PIVTC_B_FILT      6
`define PIVTC_B_DISC      5
`define PIVTC_B_FFC       4
`define PIVTC_B_RXEN      1
`define PIVTC_B_LDIS      0

// Default tag fields
`define PIVTC_PRIO_HI     7
`define PIVTC_PRIO_LO     5
`define PIVTC_VIDH_HI     3

// Reset values
`define PIVTC_RST_CTRL2   8'h02
`define PIVTC_RST_TAG_HI  8'h00
`define PIVTC_RST_TAG_LO  8'h01

// Membership bit of port 4 in the VLAN table field
`define PIVTC_MEMB_P4     3'h4

`define PIVTC_RESP_OKAY   2'h0
`define PIVTC_RESP_DECERR 2'h3

`endif

// file: src/pivtc_pkg.sv
// Types of the per-port ingress VLAN and tag control bank.
// Assumes nothing of its surroundings.
package pivtc_pkg;

  // Write channel states, Gray along idle -> half -> response
  typedef enum logic [1:0] {
    PIVTC_WR_IDLE = 2'b00,
    PIVTC_WR_ADDR = 2'b01,
    PIVTC_WR_RESP = 2'b11,
    PIVTC_WR_DATA = 2'b10
  } pivtc_wr_state_t;

  typedef enum logic [1:0] {
    PIVTC_K_CTRL2  = 2'b00,
    PIVTC_K_TAG_HI = 2'b01,
    PIVTC_K_TAG_LO = 2'b10,
    PIVTC_K_NONE   = 2'b11
  } pivtc_kind_t;

  typedef struct packed {
    logic        hit;
    logic        rsvd;
    logic [1:0]  slot;
    pivtc_kind_t kind;
  } pivtc_dec_t;

endpackage : pivtc_pkg

// file: test/pivtc_top_bench.sv
// Self-checking bench for the ingress VLAN and tag control bank.
// Assumes the bank is an AXI4-Lite slave on aclk; the bench is master.
`timescale 1ns/1ps
`include "pivtc_defs.svh"

module pivtc_top_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [8:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot, pkt_prio, res_prio;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, an_rx, an_tx, fc_rx, fc_tx, rx_en, learn_en;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, pkt_port;
  logic        pkt_valid, res_valid, res_drop, res_learn;
  logic [11:0] pkt_vid;
  logic [4:0]  pkt_vlan_member;
  logic [7:0]  m_ctrl [4];
  logic [7:0]  m_hi [4];
  logic [7:0]  m_lo [4];
  int          fails, n_checks, cycles;

  pivtc_top pivtc_top_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pkt_valid(pkt_valid), .pkt_port(pkt_port),
    .pkt_vid(pkt_vid), .pkt_prio(pkt_prio),
    .pkt_vlan_member(pkt_vlan_member), .res_valid(res_valid),
    .res_drop(res_drop), .res_prio(res_prio), .res_learn(res_learn),
    .auto_negotiation_result_rx(an_rx), .auto_negotiation_result_tx(an_tx),
    .flow_ctrl_rx_en(fc_rx), .flow_ctrl_tx_en(fc_tx),
    .rx_enable(rx_en), .learn_enable(learn_en));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Port slot of an index: 0..3 mapped, 4 reserved, -1 unmapped
  function automatic int slot_of(input logic [6:0] idx);
    if (idx[3:0] < 4'h2 || idx[3:0] > 4'h4) return -1;
    case (idx[6:4])
      3'h1: return 0;
      3'h2: return 1;
      3'h3: return 2;
      3'h4: return 4;
      3'h5: return 3;
      default: return -1;
    endcase
  endfunction : slot_of

  function automatic logic [7:0] model_rd(input logic [6:0] idx);
    int s;
    s = slot_of(idx);
    if (s < 0 || s == 4) return 8'h00;
    if (idx[3:0] == 4'h2) return m_ctrl[s];
    if (idx[3:0] == 4'h3) return m_hi[s];
    return m_lo[s];
  endfunction : model_rd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic axi_write(input logic [6:0] idx, input logic [7:0] d,
                           input logic [3:0] strb, output logic [1:0] resp);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'($urandom()), d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_ok = 1;
      end
      if (!w_ok && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_ok = 1;
      end
      if (bvalid === 1'b1)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [6:0] idx, output logic [31:0] d,
                          output logic [1:0] resp);
    bit ar_ok;
    ar_ok = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (!ar_ok && arready === 1'b1)
      begin
        arvalid <= 1'b0;
        ar_ok = 1;
      end
      if (rvalid === 1'b1)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  task automatic check_ports();
    logic [3:0] efr, eft, erx, ele;
    for (int i = 0; i < 4; i++)
    begin
      efr[i] = m_ctrl[i][`PIVTC_B_FFC] | an_rx[i];
      eft[i] = m_ctrl[i][`PIVTC_B_FFC] | an_tx[i];
      erx[i] = m_ctrl[i][`PIVTC_B_RXEN];
      ele[i] = ~m_ctrl[i][`PIVTC_B_LDIS];
    end
    #1;
    check(32'(fc_rx), 32'(efr), "rx flow control");
    check(32'(fc_tx), 32'(eft), "tx flow control");
    check(32'(rx_en), 32'(erx), "receive enable");
    check(32'(learn_en), 32'(ele), "learn enable");
  endtask : check_ports

  task automatic lookup(input int p);
    logic [11:0] dv, vid;
    logic [2:0]  pr, ep, dp;
    logic [4:0]  mem;
    logic [7:0]  c;
    logic        ed;
    c = m_ctrl[p];
    dv = {m_hi[p][`PIVTC_VIDH_HI:0], m_lo[p]};
    dp = m_hi[p][`PIVTC_PRIO_HI:`PIVTC_PRIO_LO];
    vid = ($urandom() % 2) ? dv : 12'($urandom());
    pr = 3'($urandom());
    mem = 5'($urandom());
    ed = !c[`PIVTC_B_RXEN]
       | (c[`PIVTC_B_FILT] & !mem[p == 3 ? 4 : p])
       | (c[`PIVTC_B_DISC] & (vid != dv));
    ep = (c[`PIVTC_B_CEIL] && pr > dp) ? dp : pr;
    @(posedge aclk);
    pkt_valid <= 1'b1;
    pkt_port <= 2'(p);
    pkt_vid <= vid;
    pkt_prio <= pr;
    pkt_vlan_member <= mem;
    @(posedge aclk);
    pkt_valid <= 1'b0;
    #1;
    check(32'(res_valid), 32'h1, "result valid");
    check(32'(res_drop), 32'(ed), "drop");
    check(32'(res_prio), 32'(ep), "priority");
    check(32'(res_learn), 32'(!c[`PIVTC_B_LDIS]), "learn");
    @(posedge aclk);
    #1;
    check(32'(res_valid), 32'h0, "result pulse");
  endtask : lookup

  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 4; i++)
    begin
      m_ctrl[i] = `PIVTC_RST_CTRL2;
      m_hi[i] = `PIVTC_RST_TAG_HI;
      m_lo[i] = `PIVTC_RST_TAG_LO;
    end
  endtask : reset_dut

  // Slots 1..5 of the five port blocks, mapped, reserved and unmapped
  task automatic check_all();
    logic [6:0]  idx;
    logic [31:0] d;
    logic [1:0]  r;
    for (int h = 1; h <= 5; h++)
      for (int l = 1; l <= 5; l++)
      begin
        idx = {3'(h), 4'(l)};
        axi_read(idx, d, r);
        check(d, 32'(model_rd(idx)), "read data");
        check(32'(r), slot_of(idx) < 0 ? 32'(`PIVTC_RESP_DECERR)
            : 32'(`PIVTC_RESP_OKAY), "read resp");
      end
    check_ports();
  endtask : check_all

  initial
  begin
    logic [6:0]  idx;
    logic [7:0]  d;
    logic [3:0]  strb;
    logic [31:0] rd;
    logic [1:0]  r;
    int          s;
    {awvalid, wvalid, bready, arvalid, rready, pkt_valid} = '0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {pkt_port, pkt_vid, pkt_prio, pkt_vlan_member, an_rx, an_tx} = '0;
    aresetn = 1'b0;
    void'($urandom(32'hae2b));
    reset_dut();
    check_all();
    for (int n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      an_rx <= 4'($urandom());
      an_tx <= 4'($urandom());
      idx = {3'($urandom() % 5 + 1), 4'($urandom() % 4 + 1)};
      d = 8'($urandom());
      strb = ($urandom() % 4 == 0) ? 4'he : 4'h1;
      s = slot_of(idx);
      axi_write(idx, d, strb, r);
      check(32'(r), s < 0 ? 32'(`PIVTC_RESP_DECERR)
            : 32'(`PIVTC_RESP_OKAY), "write resp");
      if (s >= 0 && s < 4 && strb[0])
        case (idx[3:0])
          4'h2: m_ctrl[s] = d;
          4'h3: m_hi[s] = d;
          default: m_lo[s] = d;
        endcase
      axi_read(idx, rd, r);
      check(rd, 32'(model_rd(idx)), "read back");
      check_ports();
      lookup($urandom() % 4);
    end
    reset_dut();
    check_all();
    report_and_stop();
  end
endmodule : pivtc_top_bench
